// ==== design/alc_cal_ctrl.sv ====
// alc_cal_ctrl: calibration trigger select, low-power background calibration
// sequencer and core gain trim, with an AXI4-Lite register slave.
// assumes the calibration engine pulses cal_done after each cal_start and the
// fuse value is stable when reset is released; the trigger pin is asynchronous.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - soft trigger bit, resets to one
// - select zero uses soft trigger bit
// - sleep code sets sleep period length
// - sleep delay only in autonomous low-power
// - wake code sets settling before calibration
// - mode bit clear: counter times sleep
// - mode bit set: trigger high sleeps
// - low-power enable needs background calibration
// - gain trim for all cores, fuse loaded
// - select one uses trigger pin level
module alc_cal_ctrl #(
    parameter logic [40:0] SLEEP_CNT_1 = 41'd4194432,
    parameter logic [40:0] SLEEP_CNT_2 = 41'd33554560,
    parameter logic [40:0] SLEEP_CNT_3 = 41'd268435584,
    parameter logic [40:0] SLEEP_CNT_4 = 41'd2147483776,
    parameter logic [40:0] SLEEP_CNT_5 = 41'd137438953600,
    parameter logic [40:0] SLEEP_CNT_6 = 41'd1099511627904,
    parameter logic [40:0] WAKE_CNT_1 = 41'd33554560,
    parameter logic [40:0] WAKE_CNT_2 = 41'd268435584,
    parameter logic [40:0] WAKE_CNT_3 = 41'd2147483776
) (
    input wire logic clk,
    input wire logic reset,
    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // external calibration trigger pin, asynchronous
    input wire logic cal_trigger_pin,
    // factory fuse value for the gain trim
    input wire logic [7:0] fuse_gain_trim,
    // calibration engine handshake
    input wire logic cal_done,
    output logic cal_start,
    // resolved trigger level and core control
    output logic cal_trigger,
    output logic core_sleep,
    output logic core_settling,
    output logic [7:0] core_gain_adjust
);

    // register storage, all eight bits kept so reserved bits read back
    logic [7:0] pin_cfg_q;
    logic [7:0] cal_software_trigger_q;
    logic [7:0] lowpower_background_cal_q;
    logic [7:0] core_gain_adjust_q;
    logic [7:0] lp_control_q;
    // one-shot fuse load after reset release
    logic fuse_load_q;
    // trigger pin synchroniser
    logic trig_meta_q;
    logic trig_sync_q;
    // sequencer
    alc_pkg::alc_state_e state_q;
    alc_pkg::alc_state_e state_d;
    logic [40:0] count_q;
    logic cal_start_q;
    // axi slave holding state
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] aw_idx_q;
    logic [7:0] w_data_q;
    logic w_lane_q;
    logic [1:0] bresp_q;
    logic bvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic rvalid_q;

    // decoded fields
    logic trigger_source_select;
    logic software_cal_trigger;
    logic lowpower_cal_enable;
    logic lowpower_trigger_mode;
    logic background_cal_enable;
    logic [2:0] core_sleep_delay;
    logic [1:0] core_wake_delay;
    logic lp_active;
    logic [40:0] sleep_count;
    logic [40:0] wake_count;
    logic do_write;
    logic wr_mapped;

    assign trigger_source_select = pin_cfg_q[alc_pkg::ALC_POS_TRIG_SEL];
    assign software_cal_trigger = cal_software_trigger_q[alc_pkg::ALC_POS_SOFT_TRIG];
    assign lowpower_cal_enable = lowpower_background_cal_q[alc_pkg::ALC_POS_LOWPOWER_CAL_ENABLE];
    assign lowpower_trigger_mode = lowpower_background_cal_q[alc_pkg::ALC_POS_LOWPOWER_TRIGGER_MODE];
    assign core_sleep_delay = lowpower_background_cal_q[alc_pkg::ALC_POS_SLEEP_LO +: 3];
    assign core_wake_delay = lowpower_background_cal_q[alc_pkg::ALC_POS_WAKE_LO +: 2];
    assign background_cal_enable = lp_control_q[alc_pkg::ALC_POS_BG_EN];

    // two flops before anything looks at the pin
    always_ff @(posedge clk) begin
        if (reset) begin
            trig_meta_q <= 1'b0;
            trig_sync_q <= 1'b0;
        end else begin
            trig_meta_q <= cal_trigger_pin;
            trig_sync_q <= trig_meta_q;
        end
    end
    // trigger source mux
    always_comb begin
        if (trigger_source_select) begin
            cal_trigger = trig_sync_q;
        end else begin
            // soft bit when select is zero
            cal_trigger = software_cal_trigger;
        end
    end
    assign lp_active = lowpower_cal_enable & background_cal_enable;
    // sleep count lookup
    always_comb begin
        unique case (core_sleep_delay)
            3'h0: sleep_count = alc_pkg::ALC_DLY_SHORT;
            3'h1: sleep_count = SLEEP_CNT_1;
            3'h2: sleep_count = SLEEP_CNT_2;
            3'h3: sleep_count = SLEEP_CNT_3;
            3'h4: sleep_count = SLEEP_CNT_4;
            3'h5: sleep_count = SLEEP_CNT_5;
            3'h6, 3'h7: sleep_count = SLEEP_CNT_6;
        endcase
    end
    // wake count lookup
    always_comb begin
        unique case (core_wake_delay)
            2'h0: wake_count = alc_pkg::ALC_DLY_SHORT;
            2'h1: wake_count = WAKE_CNT_1;
            2'h2: wake_count = WAKE_CNT_2;
            2'h3: wake_count = WAKE_CNT_3;
        endcase
    end
    // next phase of the offline core
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            alc_pkg::ALC_ST_ONLINE: begin
                if (lp_active) begin
                    state_d = alc_pkg::ALC_ST_SLEEP;
                end
            end
            alc_pkg::ALC_ST_SLEEP: begin
                if (!lp_active) begin
                    state_d = alc_pkg::ALC_ST_ONLINE;
                end else if (lowpower_trigger_mode) begin
                    if (!cal_trigger) begin
                        state_d = alc_pkg::ALC_ST_WAKE;
                    end
                end else if (count_q == 41'd1) begin
                    state_d = alc_pkg::ALC_ST_WAKE;
                end
            end
            alc_pkg::ALC_ST_WAKE: begin
                if (!lp_active) begin
                    state_d = alc_pkg::ALC_ST_ONLINE;
                end else if (count_q == 41'd1) begin
                    state_d = alc_pkg::ALC_ST_CAL;
                end
            end
            alc_pkg::ALC_ST_CAL: begin
                // a running calibration is allowed to finish
                if (cal_done) begin
                    state_d = lp_active ? alc_pkg::ALC_ST_SLEEP : alc_pkg::ALC_ST_ONLINE;
                end
            end
            default: state_d = alc_pkg::ALC_ST_ONLINE;
        endcase
    end
    // phase register
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= alc_pkg::ALC_ST_ONLINE;
        end else begin
            state_q <= state_d;
        end
    end
    // phase counter, loaded on every phase entry
    always_ff @(posedge clk) begin
        if (reset) begin
            count_q <= 41'd0;
        end else if (state_d != state_q) begin
            if (state_d == alc_pkg::ALC_ST_SLEEP) begin
                count_q <= sleep_count;
            end else if (state_d == alc_pkg::ALC_ST_WAKE) begin
                count_q <= wake_count;
            end else begin
                count_q <= 41'd0;
            end
        end else if (state_q == alc_pkg::ALC_ST_SLEEP && lowpower_trigger_mode) begin
            // sleep delay ignored in trigger mode
            count_q <= count_q;
        end else if (count_q > 41'd1) begin
            count_q <= count_q - 41'd1;
        end
    end
    // calibration start pulse on entering the calibrate phase
    always_ff @(posedge clk) begin
        if (reset) begin
            cal_start_q <= 1'b0;
        end else begin
            cal_start_q <= (state_d == alc_pkg::ALC_ST_CAL) && (state_q != alc_pkg::ALC_ST_CAL);
        end
    end

    assign cal_start = cal_start_q;
    assign core_sleep = (state_q == alc_pkg::ALC_ST_SLEEP);
    assign core_settling = (state_q == alc_pkg::ALC_ST_WAKE);
    assign core_gain_adjust = core_gain_adjust_q;

    // axi write channel acceptance; each side taken once, in either order
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign do_write = aw_have_q && w_have_q && !bvalid_q;
    // write address and data holding
    always_ff @(posedge clk) begin
        if (reset) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_idx_q <= 8'h00;
            w_data_q <= 8'h00;
            w_lane_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_idx_q <= s_axi_awaddr[9:2];
            end else if (do_write) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata[7:0];
                w_lane_q <= s_axi_wstrb[0];
            end else if (do_write) begin
                w_have_q <= 1'b0;
            end
        end
    end
    // write address decode
    always_comb begin
        unique case (aw_idx_q)
            alc_pkg::ALC_IDX_PIN_CFG, alc_pkg::ALC_IDX_SOFT_TRIG, alc_pkg::ALC_IDX_LP,
            alc_pkg::ALC_IDX_GAIN, alc_pkg::ALC_IDX_CTRL, alc_pkg::ALC_IDX_STATUS: wr_mapped = 1'b1;
            default: wr_mapped = 1'b0;
        endcase
    end
    // register writes; the fuse load takes the gain trim once after reset
    always_ff @(posedge clk) begin
        if (reset) begin
            cal_software_trigger_q <= alc_pkg::ALC_RST_SOFT_TRIG;
            pin_cfg_q <= alc_pkg::ALC_RST_PIN_CFG;
            lowpower_background_cal_q <= alc_pkg::ALC_RST_LP;
            lp_control_q <= alc_pkg::ALC_RST_CTRL;
            core_gain_adjust_q <= alc_pkg::ALC_RST_GAIN;
            fuse_load_q <= 1'b1;
        end else begin
            fuse_load_q <= 1'b0;
            if (fuse_load_q) begin
                core_gain_adjust_q <= fuse_gain_trim;
            end
            if (do_write && w_lane_q) begin
                // whole byte stored, reserved bits included
                unique case (aw_idx_q)
                    alc_pkg::ALC_IDX_PIN_CFG: pin_cfg_q <= w_data_q;
                    alc_pkg::ALC_IDX_SOFT_TRIG: cal_software_trigger_q <= w_data_q;
                    alc_pkg::ALC_IDX_LP: lowpower_background_cal_q <= w_data_q;
                    alc_pkg::ALC_IDX_GAIN: core_gain_adjust_q <= w_data_q;
                    alc_pkg::ALC_IDX_CTRL: lp_control_q <= w_data_q;
                    default: ;
                endcase
            end
        end
    end

    // write response, unmapped addresses answered with slverr
    always_ff @(posedge clk) begin
        if (reset) begin
            bvalid_q <= 1'b0;
            bresp_q <= alc_pkg::ALC_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_mapped ? alc_pkg::ALC_RESP_OKAY : alc_pkg::ALC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // read channel; one read in flight, data one cycle after the address
    assign s_axi_arready = !rvalid_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= alc_pkg::ALC_RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q <= alc_pkg::ALC_RESP_OKAY;
            unique case (s_axi_araddr[9:2])
                alc_pkg::ALC_IDX_PIN_CFG: rdata_q <= {24'h000000, pin_cfg_q};
                alc_pkg::ALC_IDX_SOFT_TRIG: rdata_q <= {24'h000000, cal_software_trigger_q};
                alc_pkg::ALC_IDX_LP: rdata_q <= {24'h000000, lowpower_background_cal_q};
                alc_pkg::ALC_IDX_GAIN: rdata_q <= {24'h000000, core_gain_adjust_q};
                alc_pkg::ALC_IDX_CTRL: rdata_q <= {24'h000000, lp_control_q};
                // live phase and resolved trigger
                alc_pkg::ALC_IDX_STATUS: rdata_q <= {27'h0000000, cal_trigger, state_q};
                default: begin
                    rdata_q <= 32'h00000000;
                    rresp_q <= alc_pkg::ALC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule : alc_cal_ctrl

`default_nettype wire

// ==== design/alc_pkg.sv ====
// alc_pkg: constants shared by the low-power calibration control block.
// assumes a 100 MHz system clock and word-aligned AXI4-Lite register access.
package alc_pkg;
    // register indices as printed; the byte address is four times the index
    localparam logic [7:0] ALC_IDX_PIN_CFG = 8'h6b;
    localparam logic [7:0] ALC_IDX_SOFT_TRIG = 8'h6c;
    localparam logic [7:0] ALC_IDX_LP = 8'h6e;
    localparam logic [7:0] ALC_IDX_GAIN = 8'h7a;
    localparam logic [7:0] ALC_IDX_CTRL = 8'h90;
    localparam logic [7:0] ALC_IDX_STATUS = 8'h91;
    // reset values
    localparam logic [7:0] ALC_RST_PIN_CFG = 8'h00;
    localparam logic [7:0] ALC_RST_SOFT_TRIG = 8'h01;
    localparam logic [7:0] ALC_RST_LP = 8'h88;
    localparam logic [7:0] ALC_RST_GAIN = 8'h00;
    localparam logic [7:0] ALC_RST_CTRL = 8'h00;
    // field positions
    localparam int ALC_POS_TRIG_SEL = 0;
    localparam int ALC_POS_SOFT_TRIG = 0;
    localparam int ALC_POS_LOWPOWER_CAL_ENABLE = 0;
    localparam int ALC_POS_LOWPOWER_TRIGGER_MODE = 1;
    localparam int ALC_POS_WAKE_LO = 3;
    localparam int ALC_POS_SLEEP_LO = 5;
    localparam int ALC_POS_BG_EN = 0;
    // delay counts in clock periods that fit below the parameter threshold
    localparam logic [40:0] ALC_DLY_SHORT = 41'h00000000480;
    // axi responses
    localparam logic [1:0] ALC_RESP_OKAY = 2'h0;
    localparam logic [1:0] ALC_RESP_SLVERR = 2'h2;
    // low-power phase of the offline core
    typedef enum logic [3:0] {
        ALC_ST_ONLINE = 4'h1,
        ALC_ST_SLEEP = 4'h2,
        ALC_ST_WAKE = 4'h4,
        ALC_ST_CAL = 4'h8
    } alc_state_e;
endpackage : alc_pkg

// ==== sim/alc_cal_ctrl_props.sv ====
// alc_cal_ctrl_props: port-level checks of the calibration control block.
// assumes it is bound to alc_cal_ctrl and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module alc_cal_ctrl_props (
    input wire logic clk,
    input wire logic reset,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cal_trigger_pin,
    input wire logic [7:0] fuse_gain_trim,
    input wire logic cal_done,
    input wire logic cal_start,
    input wire logic cal_trigger,
    input wire logic core_sleep,
    input wire logic core_settling,
    input wire logic [7:0] core_gain_adjust
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    trig_reset_high_a: assert property ($fell(reset) |-> cal_trigger)
        else $error("cal trigger low after reset");
    start_after_settle_a: assert property ($rose(cal_start) |-> $past(core_settling))
        else $error("calibration started without settling");
    sleep_not_start_a: assert property (core_sleep |=> !cal_start)
        else $error("calibration started straight from sleep");
    phase_exclusive_a: assert property (!(core_sleep && core_settling))
        else $error("sleep and settling together");
    start_one_pulse_a: assert property (cal_start |=> !cal_start)
        else $error("calibration start longer than one cycle");
    // the fuse lands one edge after release, hence the depth of two
    gain_write_only_a: assert property ($changed(core_gain_adjust) |-> $rose(s_axi_bvalid) || $past(reset, 2))
        else $error("gain trim changed without a write");
    rdata_upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    read_resp_holds_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped or changed");
    write_resp_holds_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped or changed");
    cover property ($rose(cal_start));
    cover property ($fell(core_sleep) && core_settling);
    cover property (s_axi_bvalid && s_axi_bresp == alc_pkg::ALC_RESP_SLVERR);
endmodule : alc_cal_ctrl_props
bind alc_cal_ctrl alc_cal_ctrl_props u_props (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cal_trigger_pin, .fuse_gain_trim, .cal_done, .cal_start, .cal_trigger, .core_sleep, .core_settling,
    .core_gain_adjust);
`default_nettype wire

// ==== sim/alc_cal_ctrl_tb_top.sv ====
// alc_cal_ctrl_tb_top: register, trigger and low-power sequence tests.
// assumes the engine model answers every calibration start.
`timescale 1ns/1ps
`default_nettype none
module alc_cal_ctrl_tb_top;
    localparam logic [11:0] A_PIN = {2'h0, alc_pkg::ALC_IDX_PIN_CFG, 2'h0};
    localparam logic [11:0] A_SOFT = {2'h0, alc_pkg::ALC_IDX_SOFT_TRIG, 2'h0};
    localparam logic [11:0] A_LP = {2'h0, alc_pkg::ALC_IDX_LP, 2'h0};
    localparam logic [11:0] A_GAIN = {2'h0, alc_pkg::ALC_IDX_GAIN, 2'h0};
    localparam logic [11:0] A_CTRL = {2'h0, alc_pkg::ALC_IDX_CTRL, 2'h0};
    localparam logic [11:0] A_STAT = {2'h0, alc_pkg::ALC_IDX_STATUS, 2'h0};
    localparam logic [1:0] OK = alc_pkg::ALC_RESP_OKAY;
    localparam logic [1:0] SLV = alc_pkg::ALC_RESP_SLVERR;
    // shortened counts; code 0 keeps its full length, code 7 reads as 6
    localparam int SLP [0:7] = '{1152, 20, 30, 40, 50, 60, 70, 70};
    localparam int WK [0:3] = '{1152, 30, 40, 50};
    logic clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cal_trigger_pin, cal_done, cal_start;
    logic cal_trigger, core_sleep, core_settling;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] fuse_gain_trim, core_gain_adjust;
    int mismatches, checked, cyc, starts;
    alc_cal_ctrl #(.SLEEP_CNT_1(41'(SLP[1])), .SLEEP_CNT_2(41'(SLP[2])), .SLEEP_CNT_3(41'(SLP[3])),
        .SLEEP_CNT_4(41'(SLP[4])), .SLEEP_CNT_5(41'(SLP[5])), .SLEEP_CNT_6(41'(SLP[6])),
        .WAKE_CNT_1(41'(WK[1])), .WAKE_CNT_2(41'(WK[2])), .WAKE_CNT_3(41'(WK[3]))) u_dut (.clk, .reset,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cal_trigger_pin, .fuse_gain_trim, .cal_done, .cal_start,
        .cal_trigger, .core_sleep, .core_settling, .core_gain_adjust);
    alc_cal_engine_model u_engine (.clk, .reset, .cal_start, .cal_done);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er, input int lag = 0);
        bit aw, w;
        aw = 0;
        w = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (!aw && s_axi_awready) begin
                aw = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready) begin
                w = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        // a late ready keeps the answer standing for the hold checks
        repeat (lag) @(posedge clk);
        s_axi_bready <= 1'b1;
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", er, s_axi_bresp);
    endtask : axi_wr
    task automatic axi_rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er, input int lag = 0);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        repeat (lag) @(posedge clk);
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk("rdata", exp, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
    endtask : axi_rd
    // counts the cycles that a phase output stays high
    task automatic phase_len(input bit settle, input int exp);
        int n;
        n = 0;
        while ((settle ? core_settling : core_sleep) !== 1'b1) @(posedge clk);
        while ((settle ? core_settling : core_sleep) === 1'b1) begin
            n++;
            @(posedge clk);
        end
        chk(settle ? "settle_len" : "sleep_len", exp, n);
    endtask : phase_len
    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // hang guard, far above the few thousand cycles the tests need
    always @(posedge clk) begin
        cyc++;
        // one count per calibration start pulse
        if (cal_start === 1'b1) begin
            starts++;
        end
        if (cyc == 30000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    initial begin
        {reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        s_axi_wstrb = 4'hf;
        cal_trigger_pin = 1'b0;
        fuse_gain_trim = 8'h5a;
        {mismatches, checked, cyc, starts} = 0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        chk("trigger", 32'h1, cal_trigger);
        chk("gain_port", 32'h5a, core_gain_adjust);
        axi_rd(A_SOFT, 32'h01, OK);
        axi_rd(A_LP, 32'h88, OK, 2);
        axi_rd(A_GAIN, 32'h5a, OK);
        axi_wr(A_GAIN, 32'hffffffc3, OK, 2);
        axi_rd(A_GAIN, 32'hc3, OK);
        axi_wr(A_SOFT, 32'h0, OK);
        chk("trigger", 32'h0, cal_trigger);
        cal_trigger_pin <= 1'b1;
        axi_wr(A_PIN, 32'h1, OK);
        repeat (4) @(posedge clk);
        chk("trigger", 32'h1, cal_trigger);
        cal_trigger_pin <= 1'b0;
        repeat (4) @(posedge clk);
        chk("trigger", 32'h0, cal_trigger);
        axi_wr(A_PIN, 32'h0, OK);
        axi_wr(A_SOFT, 32'h1, OK);
        chk("trigger", 32'h1, cal_trigger);
        axi_wr(12'h100, 32'h5, SLV);
        axi_rd(12'h100, 32'h0, SLV);
        // every sleep code, wake codes in turn; enable stays off at first
        for (int c = 0; c < 8; c++) begin
            axi_wr(A_CTRL, 32'h0, OK);
            axi_wr(A_LP, 32'((c << 5) | ((c % 4) << 3) | 1), OK);
            repeat (4) @(posedge clk);
            chk("sleep_off", 32'h0, core_sleep);
            axi_wr(A_CTRL, 32'h1, OK);
            phase_len(0, SLP[c]);
            phase_len(1, WK[c % 4]);
        end
        // trigger mode: sleep code ignored, trigger level rules
        axi_wr(A_CTRL, 32'h0, OK);
        chk("starts", 32'h8, starts);
        axi_wr(A_LP, 32'h8b, OK);
        axi_wr(A_CTRL, 32'h1, OK);
        repeat (1300) @(posedge clk);
        chk("sleep_held", 32'h1, core_sleep);
        axi_rd(A_STAT, 32'h12, OK);
        axi_wr(A_SOFT, 32'h0, OK);
        repeat (3) @(posedge clk);
        chk("sleep_woken", 32'h0, core_sleep);
        chk("settling", 32'h1, core_settling);
        tally_and_finish();
    end
endmodule : alc_cal_ctrl_tb_top
`default_nettype wire

// ==== sim/alc_cal_engine_model.sv ====
// alc_cal_engine_model: calibration engine that answers each start with a done pulse.
// assumes cal_start is a one-cycle pulse in the block's clock domain.
`timescale 1ns/1ps
`default_nettype none
module alc_cal_engine_model #(
    parameter int DONE_DLY = 3
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic cal_start,
    output logic cal_done
);
    int cnt_q; // cycles left until done, zero when idle
    // a few cycles of delay so the block must wait on done, not on time
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_q <= 0;
            cal_done <= 1'b0;
        end else begin
            cal_done <= (cnt_q == 1);
            if (cal_start) begin
                cnt_q <= DONE_DLY;
            end else if (cnt_q != 0) begin
                cnt_q <= cnt_q - 1;
            end
        end
    end
endmodule : alc_cal_engine_model
`default_nettype wire
